//--- rtl/cml_pkg.sv
package cml_pkg;
    localparam logic [7:0] CML_ADDR_MODE = 8'h00;
    localparam logic [7:0] CML_ADDR_LOCK = 8'h04;
    localparam logic [7:0] CML_ADDR_PCTRL = 8'h08;
    localparam logic [7:0] CML_ADDR_PSTAT = 8'h0c;
    localparam logic [7:0] CML_ADDR_KEY0 = 8'h10;
    localparam logic [7:0] CML_ADDR_KEY1 = 8'h14;
    localparam logic [7:0] CML_ADDR_KEY2 = 8'h18;
    localparam logic [7:0] CML_ADDR_KEY3 = 8'h1c;
    localparam int CML_SEC_LSB = 0;
    localparam int CML_KEYEN_LSB = 6;
    localparam int CML_LOCK_SECURED_BIT = 8;
    localparam int CML_PC_PSTOP_BIT = 0;
    localparam int CML_PC_FREEZE_BIT = 1;
    localparam int CML_PC_CANWAKE_BIT = 2;
    localparam int CML_PS_BACKDOOR_BIT = 3;
    localparam int CML_PS_DEBUG_BIT = 4;
    localparam logic [1:0] CML_SEC_UNLOCKED = 2'h2;
    localparam logic [1:0] CML_KEYEN_ON = 2'h2;
    localparam logic [15:0] CML_KEY_ZERO = 16'h0000;
    localparam logic [15:0] CML_KEY_ONES = 16'hffff;
    localparam logic [2:0] CML_PCTRL_RST = 3'h0;
    localparam logic [7:0] CML_LOCK_RST = 8'h00;
    localparam logic [2:0] CML_INIT_CYCLES = 3'h5;
    localparam int CML_KEY_WORDS = 4;
    typedef enum logic [1:0] {
        CML_RUN,
        CML_WAIT,
        CML_PSTOP,
        CML_STOP
    } cml_pwr_t;
endpackage

//--- rtl/cml_chip_mode_lock.sv
// Operation
// - Latch mode pin at reset release
// - Special mode leaves reset in debug state
// - Normal mode starts code from vector
// - Idle-halt opcode enters wait, CPU clock off
// - Reset, interrupt lines or unmasked interrupt wake
// - Pseudo-stop keeps oscillator, tick, watchdog, wakeup
// - Stop halts oscillator, freezes counters
// - Enabled CAN wake-up ends stop
// - Freeze modules while debug active if enabled
// - Debug controller clocked from reference clock
// - Copy option byte into lock copy
// - Only lock code 10 means unsecured
// - Secured normal mode disables debug controller
// - Secured restricts flash and EEPROM commands
// - Secured special mode: erase and status only
// - Normal mode back-door key unlock
// - Key words 0000 or FFFF are invalid
// - Secured state persists across resets
//
// Implementation choices: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module cml_chip_mode_lock
    import cml_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic modeSelectPin,
    input wire logic nmiLinePin,
    input wire logic extIntPin,
    input wire logic [7:0] flashOptionByte,
    input wire logic [63:0] storedBackdoorKey,
    input wire logic idleHaltExec,
    input wire logic stopExec,
    input wire logic [15:0] intPending,
    input wire logic [15:0] intLocalEnable,
    input wire logic condFlagsIMask,
    input wire logic tickEvent,
    input wire logic watchdogEvent,
    input wire logic wakeupTimerEvent,
    input wire logic canWakeEvent,
    input wire logic debugEnterReq,
    input wire logic debugExitReq,
    output logic modeSelectLatch,
    output logic activeDebugState,
    output logic resetVectorFetch,
    output logic secured,
    output logic debugEnable,
    output logic debugMemAccess,
    output logic debugCmdRestricted,
    output logic nvmCmdRestricted,
    output logic freezeModules,
    output logic debugClkFromRefClk,
    output logic cpuClkEnable,
    output logic sysClkEnable,
    output logic oscEnable,
    output logic tickWatchdogEnable,
    output logic wakeupTimerEnable,
    output logic countersFrozen
);
    // Pin inputs: bit 0 mode select, bit 1 nmi line, bit 2 ext interrupt.
    logic [2:0] sync1_reg, sync2_reg, sync3_reg, pinFilt_reg;
    logic [2:0] initCnt_reg;
    logic initDone_reg;
    logic [7:0] lockCopy_reg;
    logic [2:0] pctrl_reg;
    logic [15:0] keyWr_reg [CML_KEY_WORDS];
    logic keyCompare_reg;
    logic backdoorOk_reg;
    cml_pwr_t pwr_reg, pwr_next;
    logic busReq, busTake, waitWake, stopWake, pstopWake;
    logic lockSecure, storedKeyValid, keysMatch, debugAllowed;
    logic [31:0] readMux;
    logic [1:0] keyIdx;

    assign busReq = avs_read | avs_write;
    assign busTake = busReq & ~avs_waitrequest;
    assign keyIdx = avs_address[3:2];

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            sync1_reg <= 3'h0;
            sync2_reg <= 3'h0;
            sync3_reg <= 3'h0;
            pinFilt_reg <= 3'h0;
        end
        else
        begin
            sync1_reg <= {extIntPin, nmiLinePin, modeSelectPin};
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            pinFilt_reg <= ((sync2_reg ~^ sync3_reg) & sync3_reg)
                | ((sync2_reg ^ sync3_reg) & pinFilt_reg);
        end
    end

    // The pin is only trustworthy once the synchroniser has filled.
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            initCnt_reg <= 3'h0;
            initDone_reg <= 1'b0;
            modeSelectLatch <= 1'b0;
            lockCopy_reg <= CML_LOCK_RST;
            resetVectorFetch <= 1'b0;
        end
        else
        begin
            resetVectorFetch <= 1'b0;
            if (!initDone_reg)
            begin
                initCnt_reg <= initCnt_reg + 3'h1;
                if (initCnt_reg == CML_INIT_CYCLES - 3'h1)
                begin
                    initDone_reg <= 1'b1;
                    modeSelectLatch <= pinFilt_reg[0];
                    lockCopy_reg <= flashOptionByte;
                    resetVectorFetch <= pinFilt_reg[0];
                end
            end
        end
    end

    assign lockSecure = lockCopy_reg[CML_SEC_LSB +: 2]
        != CML_SEC_UNLOCKED;
    assign debugAllowed = ~(modeSelectLatch & lockSecure
        & ~backdoorOk_reg);

    always_comb
    begin
        storedKeyValid = 1'b1;
        keysMatch = 1'b1;
        for (int i = 0; i < CML_KEY_WORDS; i++)
        begin
            if (storedBackdoorKey[16*i +: 16] == CML_KEY_ZERO
                || storedBackdoorKey[16*i +: 16] == CML_KEY_ONES)
                storedKeyValid = 1'b0;
            if (keyWr_reg[i] != storedBackdoorKey[16*i +: 16])
                keysMatch = 1'b0;
        end
    end

    // Written key words are held until the last one arrives, then compared.
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            for (int i = 0; i < CML_KEY_WORDS; i++)
                keyWr_reg[i] <= CML_KEY_ZERO;
            keyCompare_reg <= 1'b0;
            backdoorOk_reg <= 1'b0;
        end
        else
        begin
            keyCompare_reg <= 1'b0;
            if (busTake && avs_write && avs_address >= CML_ADDR_KEY0
                && avs_address <= CML_ADDR_KEY3)
            begin
                if (avs_byteenable[0])
                    keyWr_reg[keyIdx][7:0] <= avs_writedata[7:0];
                if (avs_byteenable[1])
                    keyWr_reg[keyIdx][15:8] <= avs_writedata[15:8];
                keyCompare_reg <= (avs_address == CML_ADDR_KEY3);
            end
            if (keyCompare_reg && modeSelectLatch && storedKeyValid
                && keysMatch && lockCopy_reg[CML_KEYEN_LSB +: 2]
                == CML_KEYEN_ON)
                backdoorOk_reg <= 1'b1;
        end
    end

    // Gating is derived only from latched state, so it cannot glitch.
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            secured <= 1'b1;
            debugEnable <= 1'b0;
            debugMemAccess <= 1'b0;
            debugCmdRestricted <= 1'b1;
            nvmCmdRestricted <= 1'b1;
        end
        else
        begin
            secured <= lockSecure & ~backdoorOk_reg;
            debugEnable <= initDone_reg
                & ~(modeSelectLatch & lockSecure
                & ~backdoorOk_reg);
            debugMemAccess <= initDone_reg
                & ~(lockSecure & ~backdoorOk_reg);
            debugCmdRestricted <= ~initDone_reg
                | (lockSecure & ~backdoorOk_reg);
            nvmCmdRestricted <= ~initDone_reg
                | (lockSecure & ~backdoorOk_reg);
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            activeDebugState <= 1'b0;
        else if (initCnt_reg == CML_INIT_CYCLES - 3'h1 && !initDone_reg)
            activeDebugState <= ~pinFilt_reg[0];
        // The registered enable lags init by one edge, so the live gate is
        // used; otherwise special mode would fall out of debug at once.
        else if (!initDone_reg || !debugAllowed)
            activeDebugState <= 1'b0;
        else if (debugExitReq)
            activeDebugState <= 1'b0;
        else if (debugEnterReq)
            activeDebugState <= 1'b1;
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            freezeModules <= 1'b0;
            debugClkFromRefClk <= 1'b1;
        end
        else
        begin
            freezeModules <= activeDebugState
                & pctrl_reg[CML_PC_FREEZE_BIT];
            debugClkFromRefClk <= 1'b1;
        end
    end

    assign waitWake = pinFilt_reg[1] | pinFilt_reg[2]
        | ((|(intPending & intLocalEnable)) & ~condFlagsIMask);
    assign stopWake = pinFilt_reg[1] | pinFilt_reg[2] | wakeupTimerEvent
        | (canWakeEvent & pctrl_reg[CML_PC_CANWAKE_BIT]);
    assign pstopWake = stopWake | tickEvent | watchdogEvent;

    always_comb
    begin
        pwr_next = pwr_reg;
        case (pwr_reg)
            CML_RUN:
            begin
                if (idleHaltExec && initDone_reg)
                    pwr_next = CML_WAIT;
                else if (stopExec && initDone_reg)
                    pwr_next = pctrl_reg[CML_PC_PSTOP_BIT]
                        ? CML_PSTOP : CML_STOP;
            end
            CML_WAIT:
                if (waitWake)
                    pwr_next = CML_RUN;
            CML_PSTOP:
                if (pstopWake)
                    pwr_next = CML_RUN;
            CML_STOP:
                if (stopWake)
                    pwr_next = CML_RUN;
            default:
                pwr_next = CML_RUN;
        endcase
    end

    // Clock enables are registered from the next state so they switch
    // at the same edge as the state itself.
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            pwr_reg <= CML_RUN;
            cpuClkEnable <= 1'b1;
            sysClkEnable <= 1'b1;
            oscEnable <= 1'b1;
            tickWatchdogEnable <= 1'b1;
            wakeupTimerEnable <= 1'b1;
            countersFrozen <= 1'b0;
        end
        else
        begin
            pwr_reg <= pwr_next;
            cpuClkEnable <= pwr_next == CML_RUN;
            sysClkEnable <= pwr_next == CML_RUN
                || pwr_next == CML_WAIT;
            oscEnable <= pwr_next != CML_STOP;
            tickWatchdogEnable <= pwr_next != CML_STOP;
            wakeupTimerEnable <= 1'b1;
            countersFrozen <= pwr_next == CML_STOP;
        end
    end

    always_comb
    begin
        readMux = 32'h0;
        case (avs_address)
            CML_ADDR_MODE: readMux[0] = modeSelectLatch;
            CML_ADDR_LOCK:
            begin
                readMux[7:0] = lockCopy_reg;
                readMux[CML_LOCK_SECURED_BIT] = secured;
            end
            CML_ADDR_PCTRL: readMux[2:0] = pctrl_reg;
            CML_ADDR_PSTAT:
            begin
                readMux[1:0] = pwr_reg;
                readMux[CML_PS_BACKDOOR_BIT] = backdoorOk_reg;
                readMux[CML_PS_DEBUG_BIT] = activeDebugState;
            end
            default: readMux = 32'h0;
        endcase
    end

    // One wait state: request seen, then answered on the next edge.
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0;
        end
        else
        begin
            avs_waitrequest <= ~(busReq & avs_waitrequest);
            if (busReq && avs_waitrequest && avs_read)
                avs_readdata <= readMux;
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            pctrl_reg <= CML_PCTRL_RST;
        else if (busTake && avs_write && avs_address == CML_ADDR_PCTRL
            && avs_byteenable[0])
            pctrl_reg <= avs_writedata[2:0];
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    logic modePast;
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            modePast <= 1'b0;
        else
            modePast <= pinFilt_reg[0];
    end

    sequence s_waitEntry;
        pwr_reg == CML_WAIT && !cpuClkEnable;
    endsequence
    sequence s_backRun;
        pwr_reg == CML_RUN ##0 cpuClkEnable;
    endsequence

    property p_modeCapture;
        $rose(initDone_reg) |-> modeSelectLatch == modePast;
    endproperty
    a_modeCapture: assert property (p_modeCapture)
        else $error("Mode bit differs from sampled pin.");
    property p_specialDebug;
        $rose(initDone_reg) && !modeSelectLatch |-> activeDebugState;
    endproperty
    a_specialDebug: assert property (p_specialDebug)
        else $error("Special mode did not start in debug state.");
    property p_normalStart;
        $rose(initDone_reg) && modeSelectLatch
            |-> resetVectorFetch ##1 !resetVectorFetch;
    endproperty
    a_normalStart: assert property (p_normalStart)
        else $error("Normal mode did not fetch the vector once.");
    property p_waitEntry;
        pwr_reg == CML_RUN && idleHaltExec && initDone_reg
            |=> s_waitEntry;
    endproperty
    a_waitEntry: assert property (p_waitEntry)
        else $error("Idle-halt did not enter wait.");
    property p_waitWake;
        pwr_reg == CML_WAIT && waitWake |=> s_backRun;
    endproperty
    a_waitWake: assert property (p_waitWake)
        else $error("Wait state not left on wake source.");
    property p_pstop;
        pwr_reg == CML_PSTOP |-> oscEnable && !sysClkEnable
            && tickWatchdogEnable;
    endproperty
    a_pstop: assert property (p_pstop)
        else $error("Pseudo-stop clock enables wrong.");
    property p_stop;
        pwr_reg == CML_STOP |-> !oscEnable && countersFrozen
            && wakeupTimerEnable && !tickWatchdogEnable;
    endproperty
    a_stop: assert property (p_stop)
        else $error("Stop state clock enables wrong.");
    property p_canWake;
        pwr_reg == CML_STOP && canWakeEvent
            && pctrl_reg[CML_PC_CANWAKE_BIT] |=> pwr_reg == CML_RUN;
    endproperty
    a_canWake: assert property (p_canWake)
        else $error("CAN wake-up did not end stop.");
    property p_decode;
        initDone_reg && !backdoorOk_reg
            && lockCopy_reg[1:0] != 2'h2 |=> secured;
    endproperty
    a_decode: assert property (p_decode)
        else $error("Lock code other than 10 left part unsecured.");
    property p_nsGate;
        secured && modeSelectLatch |-> !debugEnable && !activeDebugState;
    endproperty
    a_nsGate: assert property (p_nsGate)
        else $error("Debug usable while secured in normal mode.");
    property p_ssGate;
        secured && !modeSelectLatch |-> !debugMemAccess
            && debugCmdRestricted && nvmCmdRestricted;
    endproperty
    a_ssGate: assert property (p_ssGate)
        else $error("Secured special mode not restricted.");
    property p_keyValid;
        $rose(backdoorOk_reg) |-> $past(storedKeyValid)
            && modeSelectLatch;
    endproperty
    a_keyValid: assert property (p_keyValid)
        else $error("Unlocked with an invalid key.");
endmodule // cml_chip_mode_lock
`default_nettype wire

//--- testbench/cml_debug_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module cml_debug_host_model (
    input wire logic clk,
    input wire logic reset,
    input wire logic pullLow,
    input wire logic enterCmd,
    input wire logic exitCmd,
    output logic modePin,
    output logic enterReq,
    output logic exitReq
);
    logic enterCmd_reg;
    logic exitCmd_reg;
    // The pin has a pull-up, so a released host reads as a one.
    assign modePin = pullLow ? 1'b0 : 1'b1;
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            enterCmd_reg <= 1'b0;
            exitCmd_reg <= 1'b0;
            enterReq <= 1'b0;
            exitReq <= 1'b0;
        end
        else
        begin
            enterCmd_reg <= enterCmd;
            exitCmd_reg <= exitCmd;
            enterReq <= enterCmd & ~enterCmd_reg;
            exitReq <= exitCmd & ~exitCmd_reg;
        end
    end
endmodule // cml_debug_host_model
`default_nettype wire

//--- testbench/cml_chip_mode_lock_tb.sv
`timescale 1ns/1ps
`default_nettype none
module cml_chip_mode_lock_tb;
    import cml_pkg::*;
    logic clk, reset, avsRead, avsWrite, avsWaitrequest, pullLow;
    logic [7:0] avsAddress, optByte;
    logic [31:0] avsWritedata, avsReaddata, rdData, rnd;
    logic modePin, nmiLine, extInt, idleHalt, stopX, iMask, tick, wdog;
    logic wakeTmr, canWake, enterCmd, exitCmd, enterReq, exitReq;
    logic [15:0] intPend, intEn;
    logic [63:0] storedKey, keyW;
    logic modeL, dbgAct, rvf, secured, dbgEn, dbgMem, dbgRes, nvmRes;
    logic freeze, dbgClk, cpuEn, sysEn, oscEn, tickEn, wakeEn, frozen;
    int nFail, checks, rvfCount, cycles, m, c, k;
    cml_chip_mode_lock cml_chip_mode_lock_i (.clk(clk), .reset(reset),
        .avs_address(avsAddress), .avs_read(avsRead), .avs_write(avsWrite),
        .avs_writedata(avsWritedata), .avs_byteenable(4'h3),
        .avs_readdata(avsReaddata), .avs_waitrequest(avsWaitrequest),
        .modeSelectPin(modePin), .nmiLinePin(nmiLine), .extIntPin(extInt),
        .flashOptionByte(optByte), .storedBackdoorKey(storedKey),
        .idleHaltExec(idleHalt), .stopExec(stopX), .intPending(intPend),
        .intLocalEnable(intEn), .condFlagsIMask(iMask), .tickEvent(tick),
        .watchdogEvent(wdog), .wakeupTimerEvent(wakeTmr),
        .canWakeEvent(canWake), .debugEnterReq(enterReq),
        .debugExitReq(exitReq), .modeSelectLatch(modeL),
        .activeDebugState(dbgAct), .resetVectorFetch(rvf),
        .secured(secured), .debugEnable(dbgEn), .debugMemAccess(dbgMem),
        .debugCmdRestricted(dbgRes), .nvmCmdRestricted(nvmRes),
        .freezeModules(freeze), .debugClkFromRefClk(dbgClk),
        .cpuClkEnable(cpuEn), .sysClkEnable(sysEn), .oscEnable(oscEn),
        .tickWatchdogEnable(tickEn), .wakeupTimerEnable(wakeEn),
        .countersFrozen(frozen));
    cml_debug_host_model cml_debug_host_model_i (.clk(clk), .reset(reset),
        .pullLow(pullLow), .enterCmd(enterCmd), .exitCmd(exitCmd),
        .modePin(modePin), .enterReq(enterReq), .exitReq(exitReq));
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cycles++;
        if (rvf === 1'b1)
            rvfCount++;
        if (cycles > 20000)
        begin
            nFail++;
            end_of_test();
        end
    end
    function automatic logic [31:0] lfsrNext(input logic [31:0] s);
        return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h0);
    endfunction
    function automatic logic expSec(input logic [1:0] code);
        return code !== CML_SEC_UNLOCKED;
    endfunction
    task automatic end_of_test();
        $display("nFail=%0d checks=%0d", nFail, checks);
        if (nFail == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chkBit(input logic got, input logic exp);
        checks++;
        if (got !== exp)
        begin
            nFail++;
            $display("MISMATCH t=%0t bit got %b exp %b", $time, got, exp);
        end
    endtask
    task automatic chkWord(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            nFail++;
            $display("MISMATCH t=%0t word got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic busCycle(input logic wr, input logic [7:0] a,
            input logic [31:0] d);
        @(posedge clk);
        avsAddress <= a;
        avsWritedata <= d;
        avsRead <= ~wr;
        avsWrite <= wr;
        do
            @(posedge clk);
        while (avsWaitrequest !== 1'b0);
        rdData = avsReaddata;
        avsRead <= 1'b0;
        avsWrite <= 1'b0;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic doReset(input logic special, input logic [7:0] opt);
        @(posedge clk);
        pullLow <= special;
        optByte <= opt;
        reset <= 1'b1;
        idle(12);
        rvfCount = 0;
        reset <= 1'b0;
        idle(10);
    endtask
    task automatic pwrCmd(input logic stopKind);
        @(posedge clk);
        if (stopKind)
            stopX <= 1'b1;
        else
            idleHalt <= 1'b1;
        @(posedge clk);
        stopX <= 1'b0;
        idleHalt <= 1'b0;
        idle(2);
    endtask
    task automatic chkState(input logic [1:0] st);
        busCycle(1'b0, CML_ADDR_PSTAT, 32'h0);
        chkWord({30'h0, rdData[1:0]}, {30'h0, st});
    endtask
    task automatic writeKey(input logic [63:0] kw);
        for (int i = 0; i < CML_KEY_WORDS; i++)
            busCycle(1'b1, CML_ADDR_KEY0 + 8'(4 * i), {16'h0, kw[16*i+:16]});
        idle(4);
    endtask
    initial
    begin
        reset = 1'b1; avsRead = 1'b0; avsWrite = 1'b0; avsAddress = 8'h00;
        avsWritedata = 32'h0; pullLow = 1'b0; optByte = 8'h02;
        nmiLine = 1'b0; extInt = 1'b0; idleHalt = 1'b0; stopX = 1'b0;
        iMask = 1'b0; tick = 1'b0; wdog = 1'b0; wakeTmr = 1'b0;
        canWake = 1'b0; enterCmd = 1'b0; exitCmd = 1'b0; intPend = 16'h0;
        intEn = 16'h0; storedKey = 64'h0; nFail = 0; checks = 0;
        cycles = 0; rnd = 32'h8c48;
        for (m = 0; m < 2; m++)
            for (c = 0; c < 4; c++)
            begin
                doReset(m == 0, {6'h0, 2'(c)});
                chkBit(modeL, 1'(m));
                chkBit(dbgAct, 1'(m == 0));
                chkWord(32'(rvfCount), 32'(m));
                chkBit(secured, expSec(2'(c)));
                chkBit(nvmRes, expSec(2'(c)));
                chkBit(dbgEn, !(m == 1 && expSec(2'(c))));
                chkBit(dbgClk, 1'b1);
                if (m == 0)
                begin
                    chkBit(dbgMem, !expSec(2'(c)));
                    chkBit(dbgRes, expSec(2'(c)));
                end
                busCycle(1'b0, CML_ADDR_LOCK, 32'h0);
                chkWord(rdData, {23'h0, expSec(2'(c)), 6'h0, 2'(c)});
                busCycle(1'b0, CML_ADDR_MODE, 32'h0);
                chkWord(rdData, {31'h0, 1'(m)});
                if (m == 1)
                begin
                    enterCmd <= 1'b1;
                    idle(4);
                    enterCmd <= 1'b0;
                    chkBit(dbgAct, !expSec(2'(c)));
                    exitCmd <= 1'b1;
                    idle(4);
                    exitCmd <= 1'b0;
                    chkBit(dbgAct, 1'b0);
                end
            end
        busCycle(1'b0, 8'h40, 32'h0);
        chkWord(rdData, 32'h0);
        pwrCmd(1'b0);
        chkBit(cpuEn, 1'b0);
        chkBit(sysEn, 1'b1);
        chkState(2'h1);
        rnd = lfsrNext(rnd);
        intEn <= rnd[15:0] | 16'h0001;
        intPend <= rnd[31:16] & ~(rnd[15:0] | 16'h0001);
        idle(4);
        chkState(2'h1);
        iMask <= 1'b1;
        intPend <= 16'h0001;
        idle(4);
        chkState(2'h1);
        iMask <= 1'b0;
        idle(3);
        chkBit(cpuEn, 1'b1);
        intPend <= 16'h0;
        pwrCmd(1'b0);
        extInt <= 1'b1;
        idle(6);
        extInt <= 1'b0;
        chkState(2'h0);
        busCycle(1'b1, CML_ADDR_PCTRL, 32'h1);
        pwrCmd(1'b1);
        chkState(2'h2);
        chkBit(sysEn, 1'b0);
        chkBit(oscEn, 1'b1);
        chkBit(tickEn, 1'b1);
        tick <= 1'b1;
        idle(1);
        tick <= 1'b0;
        idle(2);
        chkState(2'h0);
        for (k = 0; k < 2; k++)
        begin
            busCycle(1'b1, CML_ADDR_PCTRL, 32'(k * 4));
            pwrCmd(1'b1);
            chkState(2'h3);
            chkBit(oscEn, 1'b0);
            chkBit(frozen, 1'b1);
            chkBit(wakeEn, 1'b1);
            canWake <= 1'b1;
            idle(1);
            canWake <= 1'b0;
            idle(2);
            chkState(k ? 2'h0 : 2'h3);
            nmiLine <= 1'(k == 0);
            idle(6);
            nmiLine <= 1'b0;
            chkBit(cpuEn, 1'b1);
        end
        doReset(1'b1, 8'h02);
        busCycle(1'b1, CML_ADDR_PCTRL, 32'h2);
        idle(2);
        chkBit(freeze, 1'b1);
        busCycle(1'b1, CML_ADDR_PCTRL, 32'h0);
        idle(2);
        chkBit(freeze, 1'b0);
        for (k = 0; k < 5; k++)
        begin
            rnd = lfsrNext(rnd);
            keyW = {rnd[15:0] | 16'h0100, rnd[31:16] & 16'hfeff,
                rnd[15:0] ^ 16'h00f0, 16'h5a3c};
            if (k == 2)
                keyW[15:0] = CML_KEY_ZERO;
            if (k == 3)
                keyW[63:48] = CML_KEY_ONES;
            storedKey <= keyW;
            // Secure with the inverse of the open code.
            doReset(k == 4, k == 1 ? 8'h01 : 8'h81);
            writeKey(keyW ^ 64'h1);
            chkBit(secured, 1'b1);
            writeKey(keyW);
            chkBit(secured, k != 0);
            busCycle(1'b0, CML_ADDR_PSTAT, 32'h0);
            chkBit(rdData[CML_PS_BACKDOOR_BIT], k == 0);
            busCycle(1'b0, CML_ADDR_KEY3, 32'h0);
            chkWord(rdData, 32'h0);
        end
        doReset(1'b0, 8'h81);
        chkBit(secured, 1'b1);
        end_of_test();
    end
endmodule // cml_chip_mode_lock_tb
`default_nettype wire
